// [swe_ctrl.sv]
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module swe_fifo #(
    parameter int W = 14,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    // Honest flags straight from the occupancy count
    assign in_ready_o = count != (AW+1)'(D);
    assign out_valid_o = count != '0;
    assign out_data_o = buf_mem[rd_ptr];

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                buf_mem[wr_ptr] <= in_data_i;
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module swe_ctrl #(
    parameter int unsigned HOLD_CYCLES = swe_pkg::T_ALTER_MAX_CYC,
    parameter int unsigned HALF_CYCLES = swe_pkg::SCLK_HALF_CYC,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial link to the memory
    swe_link_if.ctl lnk
);
    import swe_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_DATA, S_READ, S_SHIFT, S_HOLD, S_PUSH
    } swe_state_type;

    // ************************************************************
    // State
    // ************************************************************
    swe_state_type state;
    logic [1:0] op;
    logic [5:0] addr_reg;
    logic [WORD_W-1:0] wdata_reg;
    logic err;
    logic [ADDR_SR_W-1:0] sh;
    logic [15:0] div;
    logic [4:0] bits;
    logic [31:0] hold_cnt;
    logic fifo_ready;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;

    // ************************************************************
    // Register access decode
    // ************************************************************
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_now = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
        {8{wb_sel_i[0]}}};
    wire [31:0] wval = wb_dat_i & wmask;
    wire busy = state != S_IDLE;
    wire go = wr_now & (wb_adr_i == REG_CTRL) & wb_sel_i[0] & ~busy;
    // Words above 49 and the spare op code are refused
    wire go_ok = go & (addr_reg < 6'(WORDS)) & (wval[1:0] != 2'h3);
    wire pop = wb_req & ~wb_we_i & (wb_adr_i == REG_RDATA);
    wire [31:0] status = {28'h0, err, ~fifo_ready, fifo_valid, busy};
    wire [31:0] rd_mux = (wb_adr_i == REG_ADDR) ? {26'h0, addr_reg} :
        (wb_adr_i == REG_WDATA) ? {18'h0, wdata_reg} :
        (wb_adr_i == REG_STATUS) ? status :
        (wb_adr_i == REG_RDATA) ? {18'h0, fifo_data & {WORD_W{fifo_valid}}} :
        32'h0;

    // Address as two one-of-ten codes, digit nine sent first
    wire [3:0] tens = 4'(addr_reg / 6'd10);
    wire [3:0] ones = 4'(addr_reg % 6'd10);
    wire [ADDR_SR_W-1:0] addr_code = {10'(10'h1 << tens), 10'(10'h1 << ones)};

    // Link clock engine: each tick ends one half period
    wire tick = div == 16'(HALF_CYCLES - 1);
    wire [4:0] target = (state == S_ADDR) ? 5'(ADDR_SR_W) :
        (state == S_READ) ? 5'h1 : 5'(WORD_W);
    // Leave a state only from the high phase, so mode lines never
    // move on a rising edge
    wire last = (state == S_HOLD) ? (hold_cnt >= HOLD_CYCLES) : (bits == target);
    wire step_done = tick & lnk.sclk & last;

    // ************************************************************
    // Bus slave: one wait state, ack drops after one cycle
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= wb_req ? rd_mux : 32'h0;
        end
    end

    // Setting registers; error flag shows whether the last start was refused, an accepted start clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= 6'h0;
            wdata_reg <= '0;
            err <= 1'b0;
        end else begin
            if (wr_now && wb_adr_i == REG_ADDR) begin
                addr_reg <= (addr_reg & ~wmask[5:0]) | wval[5:0];
            end
            if (wr_now && wb_adr_i == REG_WDATA) begin
                wdata_reg <= (wdata_reg & ~wmask[WORD_W-1:0]) | wval[WORD_W-1:0];
            end
            if (go) begin
                err <= ~go_ok;
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            op <= OP_READ;
            sh <= '0;
            div <= 16'h0;
            bits <= 5'h0;
            hold_cnt <= 32'h0;
            lnk.sclk <= 1'b1;
            {lnk.mode_select_first, lnk.mode_select_second, lnk.mode_select_third}
                <= MODE_STANDBY;
            lnk.ctl_oe_n <= 1'b1;
            lnk.ctl_data <= 1'b0;
        end else begin
            div <= (tick || state == S_IDLE || state == S_PUSH) ? 16'h0 : div + 16'h1;
            hold_cnt <= (state == S_HOLD) ? hold_cnt + 32'h1 : 32'h0;
            if (tick && !step_done && state != S_IDLE && state != S_PUSH) begin
                lnk.sclk <= ~lnk.sclk;
                if (lnk.sclk) begin
                    // Falling edge: present the next bit
                    lnk.ctl_data <= sh[ADDR_SR_W-1];
                    if (state != S_SHIFT) begin
                        sh <= {sh[ADDR_SR_W-2:0], 1'b0};
                    end
                end else begin
                    bits <= bits + 5'h1;
                    if (state == S_SHIFT) begin
                        sh <= {sh[ADDR_SR_W-2:0], lnk.line};
                    end
                end
            end
            unique case (state)
                S_IDLE: begin
                    if (go_ok) begin
                        op <= wval[1:0];
                        sh <= addr_code;
                        bits <= 5'h0;
                        state <= S_ADDR;
                        {lnk.mode_select_first, lnk.mode_select_second,
                            lnk.mode_select_third} <= MODE_ACC_ADDR;
                        lnk.ctl_oe_n <= 1'b0;
                    end
                end
                S_ADDR, S_DATA, S_READ, S_SHIFT, S_HOLD: begin
                    if (step_done) begin
                        bits <= 5'h0;
                        if (state == S_ADDR && op == OP_READ) begin
                            state <= S_READ;
                            lnk.ctl_oe_n <= 1'b1;
                            {lnk.mode_select_first, lnk.mode_select_second,
                                lnk.mode_select_third} <= MODE_READ;
                        end else if (state == S_ADDR && op == OP_WRITE) begin
                            // Erase is the software's job beforehand
                            state <= S_DATA;
                            sh <= {wdata_reg, 6'h0};
                            {lnk.mode_select_first, lnk.mode_select_second,
                                lnk.mode_select_third} <= MODE_ACC_DATA;
                        end else if (state == S_ADDR || state == S_DATA) begin
                            // Held for the longest cell time
                            state <= S_HOLD;
                            lnk.ctl_oe_n <= 1'b1;
                            {lnk.mode_select_first, lnk.mode_select_second,
                                lnk.mode_select_third} <=
                                (state == S_ADDR) ? MODE_ERASE : MODE_WRITE;
                        end else if (state == S_READ) begin
                            state <= S_SHIFT;
                            {lnk.mode_select_first, lnk.mode_select_second,
                                lnk.mode_select_third} <= MODE_SHIFT_OUT;
                        end else begin
                            // Idle code is always standby, clock parked high
                            state <= (state == S_SHIFT) ? S_PUSH : S_IDLE;
                            {lnk.mode_select_first, lnk.mode_select_second,
                                lnk.mode_select_third} <= MODE_STANDBY;
                        end
                    end
                end
                S_PUSH: begin
                    // Stalls here while the read buffer is full
                    if (fifo_ready) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Read word buffer
    // ************************************************************
    swe_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(state == S_PUSH),
        .in_ready_o(fifo_ready),
        .in_data_i(sh[WORD_W-1:0]),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data)
    );
endmodule

// [swe_pkg.sv]
package swe_pkg;

    // ************************************************************
    // Memory organisation
    // ************************************************************
    localparam int WORDS = 50;
    localparam int WORD_W = 14;
    localparam int DIGIT_W = 10;
    localparam int ADDR_SR_W = 20;
    localparam int IGNORE_BITS = 5;

    // ************************************************************
    // Mode codes, first/second/third select line from msb down
    // ************************************************************
    localparam logic [2:0] MODE_STANDBY = 3'h7;
    localparam logic [2:0] MODE_ACC_ADDR = 3'h4;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_SHIFT_OUT = 3'h2;
    localparam logic [2:0] MODE_ERASE = 3'h5;
    localparam logic [2:0] MODE_ACC_DATA = 3'h0;
    localparam logic [2:0] MODE_WRITE = 3'h1;

    // ************************************************************
    // Timing, system clock 100 MHz
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_ALTER_TYP_MS = 15;
    localparam int T_ALTER_MAX_MS = 24;
    localparam int SCLK_TYP_KHZ = 14;
    localparam int T_ALTER_TYP_CYC = T_ALTER_TYP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int T_ALTER_MAX_CYC = T_ALTER_MAX_MS * 1000000 / CLK_PERIOD_NS;
    // Half period rounded up so the link never runs above its rate
    localparam int SCLK_HALF_CYC = (1000000 + SCLK_TYP_KHZ * 2 * CLK_PERIOD_NS - 1)
        / (SCLK_TYP_KHZ * 2 * CLK_PERIOD_NS);

    // ************************************************************
    // Controller register map (byte offsets) and fields
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_AVAIL_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_ERR_BIT = 3;

    // One-of-ten code to {valid, digit}
    function automatic logic [4:0] swe_digit(input logic [DIGIT_W-1:0] code);
        logic [3:0] d;
        logic [3:0] n;
        d = 4'h0;
        n = 4'h0;
        for (int i = 0; i < DIGIT_W; i++) begin
            if (code[i]) begin
                d = 4'(i);
                n = n + 4'h1;
            end
        end
        return {n == 4'h1, d};
    endfunction

endpackage

// [swe_link_if.sv]
`timescale 1ns/1ps
interface swe_link_if;
    logic sclk;
    logic mode_select_first;
    logic mode_select_second;
    logic mode_select_third;
    logic ctl_data;
    logic ctl_oe_n;
    logic dev_data;
    logic dev_oe_n;
    logic line;

    // Shared data pin: the driving end wins, an undriven pin reads low
    assign line = !dev_oe_n ? dev_data : (!ctl_oe_n ? ctl_data : 1'b0);

    modport dev (
        input sclk, mode_select_first, mode_select_second, mode_select_third, line,
        output dev_data, dev_oe_n
    );
    modport ctl (
        input line,
        output sclk, mode_select_first, mode_select_second, mode_select_third,
        output ctl_data, ctl_oe_n
    );
endinterface

// [swe_device.sv]
`timescale 1ns/1ps
module swe_device #(
    parameter int unsigned ALTER_CYCLES = swe_pkg::T_ALTER_TYP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial link to the controller
    swe_link_if.dev lnk
);
    import swe_pkg::*;

    // ************************************************************
    // Storage and state
    // ************************************************************
    logic [WORD_W-1:0] mem [WORDS];
    logic sclk_q;
    logic [2:0] mode_q;
    logic [ADDR_SR_W-1:0] addr_sr;
    logic [WORD_W-1:0] data_sr;
    logic [WORD_W-1:0] next_data_sr;
    logic [4:0] addr_cnt;
    logic [31:0] alter_cnt;
    logic alter_done;

    // ************************************************************
    // Mode decode
    // ************************************************************
    // Mode lines taken in the order first, second, third
    wire [2:0] mode = {lnk.mode_select_first, lnk.mode_select_second,
        lnk.mode_select_third};
    wire is_addr = mode == MODE_ACC_ADDR;
    wire is_read = mode == MODE_READ;
    wire is_shift = mode == MODE_SHIFT_OUT;
    wire is_erase = mode == MODE_ERASE;
    wire is_data = mode == MODE_ACC_DATA;
    wire is_write = mode == MODE_WRITE;
    // Standby and the unused code both fall through to hold
    wire is_alter = is_erase | is_write;
    wire same_mode = mode == mode_q;

    // Link clock sampled as a plain synchronous input
    wire rise = lnk.sclk & ~sclk_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    // Upper digit in the first ten serial bits, lower in the next
    wire [4:0] upper = swe_digit(addr_sr[ADDR_SR_W-1:DIGIT_W]);
    wire [4:0] lower = swe_digit(addr_sr[DIGIT_W-1:0]);
    wire [6:0] word_num = 7'(upper[3:0]) * 7'd10 + 7'(lower[3:0]);
    // Malformed or out-of-range codes touch nothing
    wire addr_ok = upper[4] & lower[4] & (word_num < 7'(WORDS));
    wire [5:0] word_idx = word_num[5:0];

    // Pin level seen by the address shifter
    // Upper digits above four never occur, so the first five bits
    // are dropped rather than trusting a floating pin
    wire addr_bit = (addr_cnt < 5'(IGNORE_BITS)) ? 1'b0 : lnk.line;

    // Alteration fires once per mode entry, after the cell time
    wire alter_fire = is_alter & same_mode & ~alter_done
        & (alter_cnt == ALTER_CYCLES - 1);

    // ************************************************************
    // Edge and mode history
    // ************************************************************
    // Remembered so each clock pulse and each mode entry acts once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b1;
            mode_q <= MODE_STANDBY;
        end else begin
            sclk_q <= lnk.sclk;
            mode_q <= mode;
        end
    end

    // ************************************************************
    // Address register
    // ************************************************************
    // Shift one pin level per link clock in accept address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_sr <= '0;
        end else if (is_addr && rise) begin
            addr_sr <= {addr_sr[ADDR_SR_W-2:0], addr_bit};
        end
    end

    // Bit position within the address, restarts on each entry
    always_ff @(posedge clk_i) begin
        if (rst_i || !is_addr) begin
            addr_cnt <= '0;
        end else if (rise && addr_cnt != 5'h1f) begin
            addr_cnt <= addr_cnt + 5'h1;
        end
    end

    // ************************************************************
    // Data register
    // ************************************************************
    // Next value per mode; other modes keep the contents
    always_comb begin
        next_data_sr = data_sr;
        if (rise) begin
            if (is_read) begin
                next_data_sr = addr_ok ? mem[word_idx] : '0;
            end else if (is_shift) begin
                next_data_sr = {data_sr[WORD_W-2:0], 1'b0};
            end else if (is_data) begin
                next_data_sr = {data_sr[WORD_W-2:0], lnk.line};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_sr <= '0;
        end else begin
            data_sr <= next_data_sr;
        end
    end

    // ************************************************************
    // Erase and write timing
    // ************************************************************
    // Cycles spent in the alteration mode since it was entered;
    // a controller leaving early simply aborts the alteration
    always_ff @(posedge clk_i) begin
        if (rst_i || !is_alter || !same_mode) begin
            alter_cnt <= '0;
            alter_done <= 1'b0;
        end else if (!alter_done) begin
            alter_cnt <= alter_cnt + 32'h1;
            alter_done <= alter_fire;
        end
    end

    // ************************************************************
    // Word array
    // ************************************************************
    // Non-volatile cells are not cleared by reset. Write only sets
    // bits, so an unerased word keeps its old ones
    always_ff @(posedge clk_i) begin
        if (alter_fire && addr_ok) begin
            if (is_erase) begin
                mem[word_idx] <= '0;
            end else begin
                mem[word_idx] <= mem[word_idx] | data_sr;
            end
        end
    end

    // ************************************************************
    // Data pin driver
    // ************************************************************
    // Driven only in shift out, floating in every other mode;
    // the pin shows the msb of the next register value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lnk.dev_oe_n <= 1'b1;
            lnk.dev_data <= 1'b0;
        end else begin
            lnk.dev_oe_n <= ~is_shift;
            lnk.dev_data <= is_shift & next_data_sr[WORD_W-1];
        end
    end

endmodule

// [swe_link_monitor.sv]
`timescale 1ns/1ps
module swe_link_monitor import swe_pkg::*; #(
    parameter int unsigned HOLD_CYCLES = 200
) (
    // ************************************************************
    // Clock, reset and link signals
    // ************************************************************
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic mode_select_first,
    input wire logic mode_select_second,
    input wire logic mode_select_third,
    input wire logic ctl_oe_n,
    input wire logic dev_oe_n
);
    wire [2:0] m = {mode_select_first, mode_select_second, mode_select_third};
    wire alter = (m == MODE_ERASE) || (m == MODE_WRITE);
    int unsigned alt_cnt;
    // Length of the current erase or write hold
    always_ff @(posedge clk_i) begin
        alt_cnt <= (alter && !rst_i) ? alt_cnt + 1 : 0;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_standby_floats: assert property (
        m == MODE_STANDBY && $past(m) == MODE_STANDBY |-> dev_oe_n)
        else $error("device drives the pin in standby");
    a_shift_out_drives: assert property (
        m == MODE_SHIFT_OUT && $past(m) == m |-> !dev_oe_n)
        else $error("device not driving in shift out");
    a_drive_only_shift: assert property (!dev_oe_n |-> $past(m) == MODE_SHIFT_OUT)
        else $error("device drives outside shift out");
    a_no_contention: assert property (!(!dev_oe_n && !ctl_oe_n))
        else $error("both ends drive the pin");
    a_unused_code: assert property (m != 3'h6)
        else $error("unused mode code driven");
    a_load_ctl_drives: assert property (
        (m == MODE_ACC_ADDR || m == MODE_ACC_DATA) && $past(m) == m |-> !ctl_oe_n)
        else $error("controller not driving while loading");
    a_mode_in_high: assert property ($changed(m) |-> sclk && $past(sclk))
        else $error("mode changed while clock low");
    a_standby_parked: assert property (m == MODE_STANDBY && $past(m) == m |-> sclk)
        else $error("clock not parked high in standby");
    a_alter_hold: assert property ($past(alter) && !alter |-> alt_cnt >= HOLD_CYCLES)
        else $error("erase or write hold too short");
    c_read: cover property (m == MODE_READ);
    c_shift: cover property (m == MODE_SHIFT_OUT);
    c_erase: cover property (m == MODE_ERASE);
    c_write: cover property (m == MODE_WRITE);
endmodule

// [serial_word_eeprom_port_bench.sv]
`timescale 1ns/1ps
module serial_word_eeprom_port_bench;
    import swe_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ps = 1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, q;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    int miscompares = 0, n_checks = 0, ar = 0, sr = 0;
    // ************************************************************
    // Both ends joined by the link
    // ************************************************************
    swe_link_if swe_link_if_i();
    swe_device #(.ALTER_CYCLES(100)) swe_device_i (.clk_i(clk_i), .rst_i(rst_i),
        .lnk(swe_link_if_i.dev));
    swe_ctrl #(.HOLD_CYCLES(200), .HALF_CYCLES(4), .FIFO_DEPTH(8)) swe_ctrl_i (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .lnk(swe_link_if_i.ctl));
    swe_link_monitor #(.HOLD_CYCLES(200)) swe_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(swe_link_if_i.sclk), .mode_select_first(swe_link_if_i.mode_select_first),
        .mode_select_second(swe_link_if_i.mode_select_second),
        .mode_select_third(swe_link_if_i.mode_select_third),
        .ctl_oe_n(swe_link_if_i.ctl_oe_n), .dev_oe_n(swe_link_if_i.dev_oe_n));
    wire [2:0] md = {swe_link_if_i.mode_select_first, swe_link_if_i.mode_select_second,
        swe_link_if_i.mode_select_third};
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Link clock rises counted in accept address and shift out, to check frame lengths
    always @(posedge clk_i) begin
        ps <= swe_link_if_i.sclk;
        if (swe_link_if_i.sclk === 1'b1 && ps === 1'b0) begin
            if (md === MODE_ACC_ADDR) ar++;
            if (md === MODE_SHIFT_OUT) sr++;
        end
    end
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Classic single cycle; ack and read data taken at the same rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    // Start one operation and, if asked, poll until busy clears
    task automatic op(input logic [1:0] o, input logic [5:0] a, input bit wt);
        wb(1, REG_ADDR, {26'h0, a});
        wb(1, REG_CTRL, {30'h0, o});
        q = 32'h1;
        for (int i = 0; wt && i < 3000 && q[ST_BUSY_BIT] !== 1'b0; i++) wb(0, REG_STATUS, 0);
        // A poll that runs out counts as a mismatch
        if (wt) check("busy clears", {31'h0, q[ST_BUSY_BIT]}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        wb(0, a, 0);
        check(n, q, e);
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        rd(REG_STATUS, 32'h0, "status after reset");
        rd(REG_RDATA, 32'h0, "rdata empty");
        wb(1, 8'h20, 32'h5a5a);
        rd(8'h20, 32'h0, "unmapped");
        op(OP_ERASE, 7, 1);
        check("address clocks", ar, 20);
        wb(1, REG_WDATA, 32'h2a5b);
        op(OP_WRITE, 7, 1);
        op(OP_READ, 7, 1);
        rd(REG_RDATA, 32'h2a5b, "word 7");
        check("shift out clocks", sr, 14);
        op(OP_ERASE, 0, 1);
        wb(1, REG_WDATA, 32'h1555);
        op(OP_WRITE, 0, 1);
        op(OP_ERASE, 0, 1);
        op(OP_READ, 0, 1);
        rd(REG_RDATA, 32'h0, "erased word 0");
        op(OP_ERASE, 49, 1);
        wb(1, REG_WDATA, 32'h2aaa);
        op(OP_WRITE, 49, 1);
        op(OP_READ, 49, 1);
        rd(REG_RDATA, 32'h2aaa, "word 49");
        op(OP_READ, 50, 1);
        rd(REG_STATUS, 32'h8, "address 50 refused");
        op(2'h3, 7, 1);
        rd(REG_STATUS, 32'h8, "op 3 refused");
        for (int i = 0; i < 8; i++) op(OP_READ, 7, 1);
        rd(REG_STATUS, 32'h6, "fifo full");
        op(OP_READ, 7, 0);
        repeat (400) @(posedge clk_i);
        rd(REG_STATUS, 32'h7, "read stalls on full");
        rd(REG_RDATA, 32'h2a5b, "first pop");
        for (int i = 0; i < 8; i++) rd(REG_RDATA, 32'h2a5b, "drain");
        op(OP_READ, 7, 1);
        rd(REG_RDATA, 32'h2a5b, "read after drain");
        rd(REG_STATUS, 32'h0, "drained status");
        rd(REG_RDATA, 32'h0, "drained rdata");
        finish_test();
    end
endmodule
